// *** src/cpxfr_map.svh ***
`ifndef CPXFR_MAP_SVH
`define CPXFR_MAP_SVH

// ----------------------------------------------------------------------
// Instruction field positions
// ----------------------------------------------------------------------
`define CPXFR_COND_HI      31
`define CPXFR_COND_LO      28
`define CPXFR_OPC_HI       27
`define CPXFR_OPC_LO       20
`define CPXFR_SECOND_HI    19
`define CPXFR_SECOND_LO    16
`define CPXFR_FIRST_HI     15
`define CPXFR_FIRST_LO     12
`define CPXFR_CPN_HI       11
`define CPXFR_CPN_LO       8
`define CPXFR_LOWBIT_POS   5
`define CPXFR_MARK_POS     4
`define CPXFR_REG_HI       3
`define CPXFR_REG_LO       0

// ----------------------------------------------------------------------
// Field values
// ----------------------------------------------------------------------
`define CPXFR_OPC_TO_CORE  8'hC5
`define CPXFR_OPC_TO_COP   8'hC4
`define CPXFR_CPN_DOUBLE   4'hB
`define CPXFR_CPN_SINGLE   4'hA
`define CPXFR_COND_ALWAYS  4'hE
`define CPXFR_LAST_SINGLE  5'h1F

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define CPXFR_RST_WORD     32'h0000_0000
`define CPXFR_RST_REGNUM   4'h0

`endif

// *** src/cpxfr_pkg.sv ***
package cpxfr_pkg;

    typedef enum logic [2:0] {
        CPXFR_OP_NONE = 3'b000,
        CPXFR_OP_C2D  = 3'b001,
        CPXFR_OP_D2C  = 3'b010,
        CPXFR_OP_C2S  = 3'b011,
        CPXFR_OP_S2C  = 3'b100
    } cpxfr_op_e;

    typedef logic [31:0] cpxfr_word_t;
    typedef logic [4:0]  cpxfr_sidx_t;
    typedef logic [3:0]  cpxfr_cnum_t;

endpackage

// *** src/cpxfr_regfile.sv ***
`timescale 1ns/1ps
`default_nettype none

module cpxfr_regfile #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 32,
    parameter int AW    = 5
) (
    // Clock and reset
    input  wire logic             i_mclk,
    input  wire logic             i_rst_n,
    // Port a
    input  wire logic             i_we_a,
    input  wire logic [AW-1:0]    i_addr_a,
    input  wire logic [WIDTH-1:0] i_wdata_a,
    output logic      [WIDTH-1:0] o_rdata_a,
    // Port b
    input  wire logic             i_we_b,
    input  wire logic [AW-1:0]    i_addr_b,
    input  wire logic [WIDTH-1:0] i_wdata_b,
    output logic      [WIDTH-1:0] o_rdata_b
);

    initial begin
        if (DEPTH != (1 << AW) || WIDTH < 1) begin
            $error("cpxfr_regfile: DEPTH must equal 2**AW");
        end
    end

    logic [WIDTH-1:0] mem [DEPTH];

    // Read before write; ports never collide on one address
    always_ff @(posedge i_mclk) begin
        if (i_we_a) begin
            mem[i_addr_a] <= i_wdata_a;
        end
        if (i_we_b) begin
            mem[i_addr_b] <= i_wdata_b;
        end
    end

    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_rdata_a <= '0;
            o_rdata_b <= '0;
        end else begin
            o_rdata_a <= mem[i_addr_a];
            o_rdata_b <= mem[i_addr_b];
        end
    end

endmodule

`default_nettype wire

// *** src/cpxfr_top.sv ***
`include "cpxfr_map.svh"
`timescale 1ns/1ps
`default_nettype none

module cpxfr_top #(
    parameter int WORD_W = 32,
    parameter int SREGS  = 32
) (
    // Clock and reset
    input  wire logic                  i_mclk,
    input  wire logic                  i_rst_n,
    // Instruction issue
    input  wire logic                  i_issue_valid,
    input  wire logic [31:0]           i_instr,
    input  wire logic [3:0]            i_nzcv,
    input  wire cpxfr_pkg::cpxfr_word_t i_first_data,
    input  wire cpxfr_pkg::cpxfr_word_t i_second_data,
    // Issue answer
    output logic                       o_claim,
    output logic                       o_skip,
    // Data returned to the core
    output logic                       o_rd_valid,
    output cpxfr_pkg::cpxfr_cnum_t     o_first_reg,
    output cpxfr_pkg::cpxfr_cnum_t     o_second_reg,
    output cpxfr_pkg::cpxfr_word_t     o_first_data,
    output cpxfr_pkg::cpxfr_word_t     o_second_data
);
    import cpxfr_pkg::*;

    initial begin
        if (WORD_W != 32 || SREGS != 32) begin
            $error("cpxfr_top: only 32 single registers of 32 bits");
        end
    end

    // ------------------------------------------------------------------
    // Condition evaluation
    // ------------------------------------------------------------------
    function automatic logic cond_pass(input logic [3:0] c,
                                       input logic [3:0] f);
        logic n;
        logic z;
        logic cy;
        logic v;
        logic r;
        n  = f[3];
        z  = f[2];
        cy = f[1];
        v  = f[0];
        case (c[3:1])
            3'h0:    r = z;
            3'h1:    r = cy;
            3'h2:    r = n;
            3'h3:    r = v;
            3'h4:    r = cy & ~z;
            3'h5:    r = (n == v);
            3'h6:    r = ~z & (n == v);
            default: r = 1'b1;
        endcase
        // Odd codes invert, except the always code stays true
        if (c[0] && c[3:1] != 3'h7) begin
            r = ~r;
        end
        return r;
    endfunction

    // ------------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------------
    logic [7:0]  f_opc;
    logic [3:0]  f_cpn;
    logic [3:0]  f_cond;
    logic [3:0]  f_reg;
    logic        f_low;
    logic        f_mark;
    cpxfr_op_e   dec_op;
    cpxfr_sidx_t dec_idx;

    always_comb begin
        f_opc  = i_instr[`CPXFR_OPC_HI:`CPXFR_OPC_LO];
        f_cpn  = i_instr[`CPXFR_CPN_HI:`CPXFR_CPN_LO];
        f_cond = i_instr[`CPXFR_COND_HI:`CPXFR_COND_LO];
        f_reg  = i_instr[`CPXFR_REG_HI:`CPXFR_REG_LO];
        f_low  = i_instr[`CPXFR_LOWBIT_POS];
        f_mark = i_instr[`CPXFR_MARK_POS];
        dec_op = CPXFR_OP_NONE;
        if (f_mark) begin
            if (f_opc == `CPXFR_OPC_TO_CORE
                && f_cpn == `CPXFR_CPN_DOUBLE) begin
                dec_op = CPXFR_OP_D2C;
            end else if (f_opc == `CPXFR_OPC_TO_COP
                         && f_cpn == `CPXFR_CPN_DOUBLE) begin
                dec_op = CPXFR_OP_C2D;
            end else if (f_opc == `CPXFR_OPC_TO_COP
                         && f_cpn == `CPXFR_CPN_SINGLE) begin
                dec_op = CPXFR_OP_C2S;
            end else if (f_opc == `CPXFR_OPC_TO_CORE
                         && f_cpn == `CPXFR_CPN_SINGLE) begin
                dec_op = CPXFR_OP_S2C;
            end
        end
        // Doubles overlay singles: Dn is S(2n) low, S(2n+1) high
        if (dec_op == CPXFR_OP_C2D || dec_op == CPXFR_OP_D2C) begin
            dec_idx = {f_reg, 1'b0};
        end else begin
            dec_idx = {f_reg, f_low};
        end
    end

    // ------------------------------------------------------------------
    // Stage 1: accepted transfer
    // ------------------------------------------------------------------
    logic        s1_wr_r;
    logic        s1_wr_nxt;
    logic        s1_rd_r;
    logic        s1_rd_nxt;
    logic        s1_pair_r;
    logic        s1_pair_nxt;
    cpxfr_sidx_t s1_idx_r;
    cpxfr_sidx_t s1_idx_nxt;
    cpxfr_word_t s1_wa_r;
    cpxfr_word_t s1_wa_nxt;
    cpxfr_word_t s1_wb_r;
    cpxfr_word_t s1_wb_nxt;
    cpxfr_cnum_t s1_fnum_r;
    cpxfr_cnum_t s1_fnum_nxt;
    cpxfr_cnum_t s1_snum_r;
    cpxfr_cnum_t s1_snum_nxt;
    logic        claim_nxt;
    logic        skip_nxt;
    logic        go;

    always_comb begin
        go          = i_issue_valid && dec_op != CPXFR_OP_NONE
                      && cond_pass(f_cond, i_nzcv);
        claim_nxt   = go;
        skip_nxt    = i_issue_valid && dec_op != CPXFR_OP_NONE && !go;
        s1_wr_nxt   = go && (dec_op == CPXFR_OP_C2D
                             || dec_op == CPXFR_OP_C2S);
        s1_rd_nxt   = go && (dec_op == CPXFR_OP_D2C
                             || dec_op == CPXFR_OP_S2C);
        // No wrap past the last single: second half dropped
        s1_pair_nxt = dec_idx != `CPXFR_LAST_SINGLE;
        s1_idx_nxt  = go ? dec_idx : s1_idx_r;
        // Raw words, no format handling on either path
        s1_wa_nxt   = go ? i_first_data : s1_wa_r;
        s1_wb_nxt   = go ? i_second_data : s1_wb_r;
        s1_fnum_nxt = go ? i_instr[`CPXFR_FIRST_HI:`CPXFR_FIRST_LO]
                         : s1_fnum_r;
        s1_snum_nxt = go ? i_instr[`CPXFR_SECOND_HI:`CPXFR_SECOND_LO]
                         : s1_snum_r;
    end

    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            s1_wr_r   <= 1'b0;
            s1_rd_r   <= 1'b0;
            s1_pair_r <= 1'b0;
            s1_idx_r  <= '0;
            s1_wa_r   <= `CPXFR_RST_WORD;
            s1_wb_r   <= `CPXFR_RST_WORD;
            s1_fnum_r <= `CPXFR_RST_REGNUM;
            s1_snum_r <= `CPXFR_RST_REGNUM;
            o_claim   <= 1'b0;
            o_skip    <= 1'b0;
        end else begin
            s1_wr_r   <= s1_wr_nxt;
            s1_rd_r   <= s1_rd_nxt;
            s1_pair_r <= s1_pair_nxt;
            s1_idx_r  <= s1_idx_nxt;
            s1_wa_r   <= s1_wa_nxt;
            s1_wb_r   <= s1_wb_nxt;
            s1_fnum_r <= s1_fnum_nxt;
            s1_snum_r <= s1_snum_nxt;
            o_claim   <= claim_nxt;
            o_skip    <= skip_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Register file: port a carries the first word, port b the second
    // ------------------------------------------------------------------
    cpxfr_word_t rd_a;
    cpxfr_word_t rd_b;
    cpxfr_sidx_t idx_b;

    always_comb begin
        idx_b = s1_idx_r + 5'h01;
    end

    cpxfr_regfile #(
        .WIDTH (WORD_W),
        .DEPTH (SREGS),
        .AW    (5)
    ) u_regs (
        .i_mclk    (i_mclk),
        .i_rst_n   (i_rst_n),
        .i_we_a    (s1_wr_r),
        .i_addr_a  (s1_idx_r),
        .i_wdata_a (s1_wa_r),
        .o_rdata_a (rd_a),
        .i_we_b    (s1_wr_r && s1_pair_r),
        .i_addr_b  (idx_b),
        .i_wdata_b (s1_wb_r),
        .o_rdata_b (rd_b)
    );

    // ------------------------------------------------------------------
    // Stage 2: read tracking
    // ------------------------------------------------------------------
    logic        s2_rd_r;
    logic        s2_rd_nxt;
    logic        s2_pair_r;
    logic        s2_pair_nxt;
    cpxfr_cnum_t s2_fnum_r;
    cpxfr_cnum_t s2_fnum_nxt;
    cpxfr_cnum_t s2_snum_r;
    cpxfr_cnum_t s2_snum_nxt;

    always_comb begin
        s2_rd_nxt   = s1_rd_r;
        s2_pair_nxt = s1_pair_r;
        s2_fnum_nxt = s1_fnum_r;
        s2_snum_nxt = s1_snum_r;
    end

    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            s2_rd_r   <= 1'b0;
            s2_pair_r <= 1'b0;
            s2_fnum_r <= `CPXFR_RST_REGNUM;
            s2_snum_r <= `CPXFR_RST_REGNUM;
        end else begin
            s2_rd_r   <= s2_rd_nxt;
            s2_pair_r <= s2_pair_nxt;
            s2_fnum_r <= s2_fnum_nxt;
            s2_snum_r <= s2_snum_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Return to the core
    // ------------------------------------------------------------------
    logic        rv_nxt;
    cpxfr_cnum_t fr_nxt;
    cpxfr_cnum_t sr_nxt;
    cpxfr_word_t fd_nxt;
    cpxfr_word_t sd_nxt;

    always_comb begin
        rv_nxt = s2_rd_r;
        fr_nxt = s2_rd_r ? s2_fnum_r : o_first_reg;
        sr_nxt = s2_rd_r ? s2_snum_r : o_second_reg;
        fd_nxt = s2_rd_r ? rd_a : o_first_data;
        // Pair starting at the last single has no second register
        if (s2_rd_r) begin
            sd_nxt = s2_pair_r ? rd_b : `CPXFR_RST_WORD;
        end else begin
            sd_nxt = o_second_data;
        end
    end

    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_rd_valid    <= 1'b0;
            o_first_reg   <= `CPXFR_RST_REGNUM;
            o_second_reg  <= `CPXFR_RST_REGNUM;
            o_first_data  <= `CPXFR_RST_WORD;
            o_second_data <= `CPXFR_RST_WORD;
        end else begin
            o_rd_valid    <= rv_nxt;
            o_first_reg   <= fr_nxt;
            o_second_reg  <= sr_nxt;
            o_first_data  <= fd_nxt;
            o_second_data <= sd_nxt;
        end
    end

endmodule

`default_nettype wire

// *** dv/cpxfr_tb_cond.svh ***
// Included into each module's own scope, so no guard: a guard would hide
// the function from the second module compiled in the same unit
// Flags are N,Z,C,V in bits 3..0; code F behaves as always
function automatic logic cpxfr_cond_ok(input logic [3:0] c,
                                       input logic [3:0] f);
    logic r;
    case (c[3:1])
        3'h0: r = f[2];
        3'h1: r = f[1];
        3'h2: r = f[3];
        3'h3: r = f[0];
        3'h4: r = f[1] && !f[2];
        3'h5: r = f[3] == f[0];
        3'h6: r = !f[2] && (f[3] == f[0]);
        default: r = 1'b1;
    endcase
    return (c[0] && c[3:1] != 3'h7) ? !r : r;
endfunction

// *** dv/cpxfr_chk_sva.sv ***
`timescale 1ns/1ps
`default_nettype none
module cpxfr_chk (
    // Clock and reset
    input wire logic                   i_mclk,
    input wire logic                   i_rst_n,
    // Issue side
    input wire logic                   i_issue_valid,
    input wire logic [31:0]            i_instr,
    input wire logic [3:0]             i_nzcv,
    input wire cpxfr_pkg::cpxfr_word_t i_first_data,
    input wire cpxfr_pkg::cpxfr_word_t i_second_data,
    // Answer side
    input wire logic                   o_claim,
    input wire logic                   o_skip,
    input wire logic                   o_rd_valid,
    input wire cpxfr_pkg::cpxfr_cnum_t o_first_reg,
    input wire cpxfr_pkg::cpxfr_cnum_t o_second_reg,
    input wire cpxfr_pkg::cpxfr_word_t o_first_data,
    input wire cpxfr_pkg::cpxfr_word_t o_second_data
);
    import cpxfr_pkg::*;
    `include "cpxfr_tb_cond.svh"
    logic       rec;
    logic       ok;
    logic       go_rd;
    logic       go_wr;
    logic [3:0] f_num;
    logic [3:0] s_num;
    // Opcode C4/C5 and coproc A/B differ only in their low bits
    assign rec = i_instr[4] && i_instr[27:21] == 7'h62
                 && i_instr[11:9] == 3'h5;
    assign ok = cpxfr_cond_ok(i_instr[31:28], i_nzcv);
    assign go_rd = i_issue_valid && rec && ok && i_instr[20];
    assign go_wr = i_issue_valid && rec && ok && !i_instr[20];
    assign f_num = i_instr[15:12];
    assign s_num = i_instr[19:16];
    default clocking @(posedge i_mclk); endclocking
    default disable iff (!i_rst_n);
    answer_excl_a: assert property (!(o_claim && o_skip))
        else $error("claim and skip together");
    foreign_quiet_a: assert property (
        i_issue_valid && !rec |=> !o_claim && !o_skip)
        else $error("unrecognised word answered");
    cond_answer_a: assert property (i_issue_valid && rec |=>
        o_claim == $past(ok) && o_skip == !$past(ok))
        else $error("claim or skip wrong for condition");
    read_time_a: assert property (go_rd |-> ##3 o_rd_valid)
        else $error("read data late");
    read_regs_a: assert property (go_rd |-> ##3
        o_first_reg == $past(f_num, 3) && o_second_reg == $past(s_num, 3))
        else $error("returned register numbers wrong");
    read_cause_a: assert property (o_rd_valid |-> $past(go_rd, 3))
        else $error("read data without a passed read");
    read_hold_a: assert property (!o_rd_valid |->
        $stable(o_first_data) && $stable(o_second_data)
        && $stable(o_first_reg) && $stable(o_second_reg))
        else $error("read outputs moved");
    write_silent_a: assert property (go_wr |-> ##3 !o_rd_valid)
        else $error("write returned data");
endmodule
bind cpxfr_top cpxfr_chk cpxfr_chk_inst (.i_mclk(i_mclk),
    .i_rst_n(i_rst_n), .i_issue_valid(i_issue_valid), .i_instr(i_instr),
    .i_nzcv(i_nzcv), .i_first_data(i_first_data),
    .i_second_data(i_second_data), .o_claim(o_claim), .o_skip(o_skip),
    .o_rd_valid(o_rd_valid), .o_first_reg(o_first_reg),
    .o_second_reg(o_second_reg), .o_first_data(o_first_data),
    .o_second_data(o_second_data));
`default_nettype wire

// *** dv/cpxfr_core_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module cpxfr_core_model (
    // Clock
    input wire logic                   i_mclk,
    // Issue and return
    input wire logic [31:0]            i_instr,
    input wire logic                   i_rd_valid,
    input wire cpxfr_pkg::cpxfr_cnum_t i_first_reg,
    input wire cpxfr_pkg::cpxfr_cnum_t i_second_reg,
    input wire cpxfr_pkg::cpxfr_word_t i_first_data,
    input wire cpxfr_pkg::cpxfr_word_t i_second_data,
    // Operand values
    output cpxfr_pkg::cpxfr_word_t     o_first_data,
    output cpxfr_pkg::cpxfr_word_t     o_second_data
);
    import cpxfr_pkg::*;
    // Bench preloads these; pc and pair start 31 never named
    cpxfr_word_t regs [16];
    // Operands follow the fields even when idle, so stale values move
    assign o_first_data = regs[i_instr[15:12]];
    assign o_second_data = regs[i_instr[19:16]];
    always @(posedge i_mclk) begin
        if (i_rd_valid) begin
            regs[i_first_reg] <= i_first_data;
            regs[i_second_reg] <= i_second_data;
        end
    end
endmodule
`default_nettype wire

// *** dv/testbench.sv ***
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import cpxfr_pkg::*;
    `include "cpxfr_tb_cond.svh"
    logic         i_mclk = 1'b0;
    logic         i_rst_n = 1'b0;
    logic         i_issue_valid;
    logic [31:0]  i_instr;
    logic [3:0]   i_nzcv;
    cpxfr_word_t  first_w;
    cpxfr_word_t  second_w;
    logic         o_claim;
    logic         o_skip;
    logic         o_rd_valid;
    cpxfr_cnum_t  o_first_reg;
    cpxfr_cnum_t  o_second_reg;
    cpxfr_word_t  o_first_data;
    cpxfr_word_t  o_second_data;
    logic [31:0]  seed;
    cpxfr_word_t  sref [32];
    cpxfr_word_t  creg [16];
    logic [1:0]   qf [$];
    logic [71:0]  qr [$];
    int           fail_count = 0;
    int           n_tests = 0;
    always #2 i_mclk = ~i_mclk;
    cpxfr_top cpxfr_top_inst (.i_mclk(i_mclk), .i_rst_n(i_rst_n),
        .i_issue_valid(i_issue_valid), .i_instr(i_instr), .i_nzcv(i_nzcv),
        .i_first_data(first_w), .i_second_data(second_w),
        .o_claim(o_claim), .o_skip(o_skip), .o_rd_valid(o_rd_valid),
        .o_first_reg(o_first_reg), .o_second_reg(o_second_reg),
        .o_first_data(o_first_data), .o_second_data(o_second_data));
    cpxfr_core_model cpxfr_core_model_inst (.i_mclk(i_mclk),
        .i_instr(i_instr), .i_rd_valid(o_rd_valid),
        .i_first_reg(o_first_reg), .i_second_reg(o_second_reg),
        .i_first_data(o_first_data), .i_second_data(o_second_data),
        .o_first_data(first_w), .o_second_data(second_w));
    // ----
    // Helpers
    // ----
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    // Distinct core regs below 15, pair never starts at 31
    function automatic logic [31:0] mk(input logic [3:0] c, input logic d,
                                       input logic b, input logic [31:0] r);
        logic [3:0] f;
        logic [3:0] s;
        logic       m;
        f = (r[3:0] == 4'hF) ? 4'h0 : r[3:0];
        s = 4'((32'(f) + 1 + 32'(r[7:4]) % 14) % 15);
        m = !b && r[12] && r[11:8] != 4'hF;
        return {c, 7'h62, d, s, f, 3'h5, b, 2'h0, m, r[15:13] != 3'h0,
                r[11:8]};
    endfunction
    task automatic setc(input logic [3:0] k, input cpxfr_word_t v);
        creg[k] = v;
        cpxfr_core_model_inst.regs[k] = v;
    endtask
    task automatic issue(input logic [31:0] w, input logic [3:0] f);
        logic       ok;
        logic [4:0] idx;
        @(negedge i_mclk);
        i_issue_valid = 1'b1;
        i_instr = w;
        i_nzcv = f;
        ok = cpxfr_cond_ok(w[31:28], f);
        idx = w[8] ? {w[3:0], 1'b0} : {w[3:0], w[5]};
        if (w[4]) qf.push_back({ok, !ok});
        if (w[4] && ok && w[20]) begin
            qr.push_back({w[15:12], w[19:16], sref[idx], sref[idx + 5'h1]});
            creg[w[15:12]] = sref[idx];
            creg[w[19:16]] = sref[idx + 5'h1];
        end else if (w[4] && ok) begin
            sref[idx] = creg[w[15:12]];
            sref[idx + 5'h1] = creg[w[19:16]];
        end
        // Operands must stand until sampled; later preloads come after
        @(posedge i_mclk);
        #1;
    endtask
    task automatic idle(input int n);
        repeat (n) begin
            @(negedge i_mclk);
            i_issue_valid = 1'b0;
            i_instr = xs();
            i_nzcv = 4'(xs());
        end
    endtask
    task automatic cmp_flag(input logic [1:0] got, input logic [1:0] exp);
        n_tests++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic cmp_read(input logic [71:0] got, input logic [71:0] exp);
        n_tests++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic complete_run();
        $display("tests=%0d fails=%0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // ----
    // Result watcher
    // ----
    always @(negedge i_mclk) begin
        if (o_claim || o_skip)
            cmp_flag({o_claim, o_skip}, qf.size() ? qf.pop_front() : 2'bxx);
        if (o_rd_valid)
            cmp_read({o_first_reg, o_second_reg, o_first_data, o_second_data},
                     qr.size() ? qr.pop_front() : 'x);
    end
    initial begin
        #20000;
        fail_count++;
        complete_run();
    end
    // ----
    // Stimulus
    // ----
    initial begin
        logic [31:0] r;
        logic [31:0] w;
        seed = 32'hAB56878E;
        i_issue_valid = 1'b0;
        i_instr = 32'h0000_0000;
        i_nzcv = 4'h0;
        for (int k = 0; k < 16; k++) setc(k[3:0], xs());
        repeat (2) @(negedge i_mclk);
        i_rst_n = 1'b1;
        // Fill every double first, back to back
        for (int n = 0; n < 16; n++) begin
            w = mk(4'hE, 1'b0, 1'b1, xs());
            w[3:0] = n[3:0];
            w[4] = 1'b1;
            issue(w, 4'(xs()));
        end
        // Mixed forms, all conditions, reads right after writes
        for (int i = 0; i < 300; i++) begin
            r = xs();
            setc(r[23:20], xs());
            w = mk(r[31:28], r[17], r[18], xs());
            issue(w, r[27:24]);
            if (w[20]) idle(4);
            else if (r[19]) idle(1);
        end
        idle(6);
        if (qf.size() != 0 || qr.size() != 0) fail_count++;
        complete_run();
    end
endmodule
`default_nettype wire
